// ### hw/ucse_top.sv
// Purpose: Checksums, smart-card timing flags and event interrupts of a UART.
// Assumes: Byte strobes, break and error events come from the UART core on core_clk.
// Notes: Flags are cleared by writing one; a set in the same cycle wins.
`include "ucse_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ucse_top
    import ucse_pkg::*;
#(
    parameter int ETU_W = 16
) (
    input  wire logic                     core_clk,
    input  wire logic                     reset_n,
    input  wire logic [`UCSE_ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [15:0]              reg_rdata,
    input  wire ucse_mode_t               line_mode,
    input  wire logic                     tx_byte_valid,
    input  wire logic [7:0]               tx_byte,
    input  wire logic                     tx_byte_is_pid,
    input  wire logic                     rx_byte_valid,
    input  wire logic [7:0]               rx_byte,
    input  wire logic                     break_seen,
    input  wire logic                     rx_pin,
    input  wire logic                     rx_char_error,
    input  wire logic                     tx_char_error,
    input  wire logic                     waiting_expired,
    input  wire logic                     rate_detect_final_edge,
    output logic                          bit_sense_inverse,
    output logic                          card_protocol_t1,
    output logic      [1:0]               retry_count_select,
    output logic                          error_hold_low,
    output logic                          card_irq,
    output logic                          event_irq
);
    typedef struct packed {
        logic [7:0]       tx_sum_value;
        logic [7:0]       rx_sum_value;
        logic [1:0]       retry_count_select;
        logic             bit_sense_select;
        logic             error_hold_low_length;
        logic             card_protocol_select;
        logic [5:0]       sc_flags;
        logic [5:0]       sc_enables;
        logic             line_resume_flag;
        logic             rate_detect_done_flag;
        logic             rate_detect_irq_enable;
        logic             sum_accumulate_enable;
        logic             wake_enable;
        logic             rate_detect_enable;
        logic [8:0]       guard_cnt;
        logic [8:0]       block_cnt;
        logic [ETU_W-1:0] etu_div;
        logic [ETU_W-1:0] etu_cnt;
        logic [2:0]       rx_tries;
        logic [1:0]       tx_tries;
        ucse_err_t        err_state;
        logic             err_units;
        logic [1:0]       rx_sync;
        logic             rx_prev;
        logic [15:0]      rdata;
    } ucse_state_t;

    ucse_state_t s_q;
    ucse_state_t s_d;
    logic [7:0]  tx_next;
    logic [7:0]  rx_next;
    logic        etu_tick;
    logic        is_lin;
    logic        wr_sum;

    ucse_sum8 u_tx_sum (
        .acc  (s_q.tx_sum_value),
        .data (tx_byte),
        .sum  (tx_next)
    );
    ucse_sum8 u_rx_sum (
        .acc  (s_q.rx_sum_value),
        .data (rx_byte),
        .sum  (rx_next)
    );

    function automatic logic [15:0] read_mux(input ucse_state_t s,
                                             input logic [`UCSE_ADDR_W-1:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            `UCSE_OFS_TXSUM: v = {8'h00, s.tx_sum_value};
            `UCSE_OFS_RXSUM: v = {8'h00, s.rx_sum_value};
            `UCSE_OFS_SCCFG: v = {10'h000, s.retry_count_select, s.bit_sense_select,
                                  s.error_hold_low_length, s.card_protocol_select, 1'b0};
            `UCSE_OFS_SCIRQ: v = {2'h0, s.sc_flags[5:4], 1'b0, s.sc_flags[2:0],
                                  2'h0, s.sc_enables[5:4], 1'b0, s.sc_enables[2:0]};
            `UCSE_OFS_EVIRQ: v = {8'h00, s.line_resume_flag, s.rate_detect_done_flag,
                                  3'h0, s.rate_detect_irq_enable, 2'h0};
            `UCSE_OFS_CTRL:  v = {11'h000, s.rate_detect_enable, s.wake_enable,
                                  s.sum_accumulate_enable, 2'h0};
            `UCSE_OFS_GUARD: v = {7'h00, s.guard_cnt};
            `UCSE_OFS_BLOCK: v = {7'h00, s.block_cnt};
            `UCSE_OFS_ETU:   v = 16'(s.etu_div);
            default:         v = 16'h0000; // R14
        endcase
        return v;
    endfunction

    always_comb begin
        logic [15:0] sc_set;
        sc_set = 16'h0000;
        s_d = s_q;
        is_lin = (line_mode == UCSE_MODE_LIN) || (line_mode == UCSE_MODE_LIN_NOID);
        wr_sum = reg_wr;

        // Synchronise the receive pin before edge detection.
        s_d.rx_sync = {s_q.rx_sync[0], rx_pin};
        s_d.rx_prev = s_q.rx_sync[1];

        // Bit clock of one elementary time unit.
        etu_tick = (s_q.etu_cnt == '0);
        s_d.etu_cnt = etu_tick ? s_q.etu_div : s_q.etu_cnt - 1'b1; // R15

        // Checksums.
        if (is_lin) begin
            if (tx_byte_valid && !(line_mode == UCSE_MODE_LIN_NOID && tx_byte_is_pid)) begin
                s_d.tx_sum_value = tx_next; // R1
            end
            if (rx_byte_valid) begin
                s_d.rx_sum_value = rx_next;
            end
            if (break_seen) begin
                s_d.tx_sum_value = 8'h00; // R2
                s_d.rx_sum_value = 8'h00; // R2
            end
        end else if (s_q.sum_accumulate_enable) begin
            if (tx_byte_valid) begin
                s_d.tx_sum_value = tx_next; // R3
            end
            if (rx_byte_valid) begin
                s_d.rx_sum_value = rx_next; // R4
            end
        end // R5

        // Smart-card counters run on the bit clock.
        if (etu_tick && s_q.guard_cnt != '0) begin
            s_d.guard_cnt = s_q.guard_cnt - 1'b1; // R15
            sc_set[0] = (s_q.guard_cnt == 9'h001);
        end
        if (etu_tick && s_q.block_cnt != '0) begin
            s_d.block_cnt = s_q.block_cnt - 1'b1; // R15
            sc_set[2] = (s_q.block_cnt == 9'h001); // R9
        end
        sc_set[1] = waiting_expired;

        // Receive repeat: fifth erroneous reception of the same character.
        if (rx_byte_valid) begin
            if (rx_char_error) begin
                if (s_q.rx_tries == `UCSE_RX_LAST) begin
                    sc_set[5] = 1'b1; // R8
                    s_d.rx_tries = 3'h0;
                end else begin
                    s_d.rx_tries = s_q.rx_tries + 1'b1;
                end
            end else begin
                s_d.rx_tries = 3'h0;
            end
        end

        // Transmit repeat: error after the last retransmit selected.
        if (tx_char_error) begin
            if (s_q.tx_tries == s_q.retry_count_select) begin
                sc_set[4] = 1'b1; // R6
                s_d.tx_tries = 2'h0;
            end else begin
                s_d.tx_tries = s_q.tx_tries + 1'b1;
            end
        end else if (tx_byte_valid) begin
            s_d.tx_tries = 2'h0;
        end

        // T=0 error pull-down of one or two units.
        case (s_q.err_state)
            UCSE_ERR_IDLE: begin
                if (rx_char_error && rx_byte_valid && !s_q.card_protocol_select) begin
                    s_d.err_state = UCSE_ERR_HOLD;
                    s_d.err_units = s_q.error_hold_low_length; // R7
                    s_d.etu_cnt = s_q.etu_div;
                end
            end
            UCSE_ERR_HOLD: begin
                if (etu_tick) begin
                    if (s_q.err_units) begin
                        s_d.err_units = 1'b0; // R7
                    end else begin
                        s_d.err_state = UCSE_ERR_IDLE;
                    end
                end
            end
            default: s_d.err_state = UCSE_ERR_IDLE;
        endcase

        // Register writes; write-one clears lose to a same-cycle set.
        if (wr_sum) begin
            case (reg_addr)
                `UCSE_OFS_TXSUM: s_d.tx_sum_value = reg_wdata[7:0];
                `UCSE_OFS_RXSUM: s_d.rx_sum_value = reg_wdata[7:0];
                `UCSE_OFS_SCCFG: begin
                    s_d.retry_count_select    = reg_wdata[5:4]; // R6
                    s_d.bit_sense_select      = reg_wdata[3]; // R16
                    s_d.error_hold_low_length = reg_wdata[2]; // R7
                    s_d.card_protocol_select  = reg_wdata[1]; // R16
                end
                `UCSE_OFS_SCIRQ: begin
                    s_d.sc_flags   = s_q.sc_flags & ~{reg_wdata[13:12], 1'b0, reg_wdata[10:8]};
                    s_d.sc_enables = {reg_wdata[5:4], 1'b0, reg_wdata[2:0]};
                end
                `UCSE_OFS_EVIRQ: begin
                    s_d.line_resume_flag       = s_q.line_resume_flag & ~reg_wdata[7]; // R12
                    s_d.rate_detect_done_flag  = s_q.rate_detect_done_flag & ~reg_wdata[6];
                    s_d.rate_detect_irq_enable = reg_wdata[2];
                end
                `UCSE_OFS_CTRL: begin
                    s_d.sum_accumulate_enable = reg_wdata[2];
                    s_d.wake_enable           = reg_wdata[3];
                    s_d.rate_detect_enable    = reg_wdata[4];
                end
                `UCSE_OFS_GUARD: s_d.guard_cnt = reg_wdata[8:0];
                `UCSE_OFS_BLOCK: s_d.block_cnt = reg_wdata[8:0];
                `UCSE_OFS_ETU:   s_d.etu_div = reg_wdata[ETU_W-1:0];
                default: ;
            endcase
        end

        s_d.sc_flags = s_d.sc_flags | {sc_set[5:4], 1'b0, sc_set[2:0]}; // R17
        if (s_q.wake_enable && s_q.rx_prev && !s_q.rx_sync[1]) begin
            s_d.line_resume_flag = 1'b1; // R10
        end
        if (s_q.rate_detect_enable && rate_detect_final_edge) begin
            s_d.rate_detect_done_flag = 1'b1; // R11
        end

        s_d.rdata = reg_rd ? read_mux(s_q, reg_addr) : 16'h0000; // R14
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q         <= '0;
            s_q.etu_div <= ETU_W'(`UCSE_ETU_RESET);
            s_q.rx_sync <= 2'h3;
            s_q.rx_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata          = s_q.rdata;
    assign bit_sense_inverse  = s_q.bit_sense_select; // R16
    assign card_protocol_t1   = s_q.card_protocol_select; // R16
    assign retry_count_select = s_q.retry_count_select;
    assign error_hold_low     = (s_q.err_state == UCSE_ERR_HOLD); // R7
    assign card_irq           = |(s_q.sc_flags & s_q.sc_enables); // R17
    assign event_irq          = s_q.line_resume_flag
                              | (s_q.rate_detect_done_flag & s_q.rate_detect_irq_enable); // R13
endmodule
`default_nettype wire

// ### include/ucse_defines.svh
// Purpose: Constants for the checksum, smart-card and event interrupt block.
// Assumes: Register offsets chosen for a plain 16-bit register port.
// Notes: Widths and field positions live here; types live in the package.
//
// How it works
// [R1] LIN variant without identifier: transmit sum excludes the protected identifier byte.
// [R2] In LIN modes a detected break clears both checksum accumulators.
// [R3] Outside LIN, enable set: each sent byte adds with end-around carry.
// [R4] Outside LIN, enable set: each received byte adds with end-around carry.
// [R5] Outside LIN, enable clear: both sums hold except software writes.
// [R6] A 2-bit field selects the smart-card retransmit count.
// [R7] T=0 error pull-down lasts two units when the length bit is 1, else one.
// [R8] Receive-repeat flag sets when an error persists after five receptions.
// [R9] Block-time flag sets when the block counter reaches zero.
// [R10] With wake enabled a falling receive edge sets the wake flag and interrupts.
// [R11] With rate detection enabled its final falling edge sets the done flag.
// [R12] Software clears the wake and rate-detect flags; hardware only sets them.
// [R13] The rate-detect flag interrupts only while its enable bit is 1.
// [R14] Unimplemented register bits read as zero.
// [R15] Guard and block counters run on a bit clock of one elementary unit.
// [R16] Convention bit selects inverse or direct; protocol bit selects T=1 or T=0.
// [R17] Each smart-card flag is hardware set and interrupts only when enabled.
`ifndef UCSE_DEFINES_SVH
`define UCSE_DEFINES_SVH
`define UCSE_ADDR_W        4
`define UCSE_OFS_TXSUM     4'h0
`define UCSE_OFS_RXSUM     4'h1
`define UCSE_OFS_SCCFG     4'h2
`define UCSE_OFS_SCIRQ     4'h3
`define UCSE_OFS_EVIRQ     4'h4
`define UCSE_OFS_CTRL      4'h5
`define UCSE_OFS_GUARD     4'h6
`define UCSE_OFS_BLOCK     4'h7
`define UCSE_OFS_ETU       4'h8
`define UCSE_SCCFG_MASK    16'h003E
`define UCSE_SCIRQ_FMASK   16'h3700
`define UCSE_SCIRQ_EMASK   16'h0037
`define UCSE_EVIRQ_MASK    16'h00C4
`define UCSE_CTRL_MASK     16'h001F
`define UCSE_CNT_MASK      16'h01FF
`define UCSE_RX_LIMIT      3'h5
`define UCSE_RX_LAST       3'h4
`define UCSE_ETU_RESET     16'h0174
`endif

// ### include/ucse_pkg.sv
// Purpose: Types for the checksum, smart-card and event interrupt block.
// Assumes: Used together with ucse_defines.svh.
// Notes: The mode encodes the line protocol family.
package ucse_pkg;
    typedef enum logic [1:0] {
        UCSE_MODE_PLAIN,
        UCSE_MODE_LIN,
        UCSE_MODE_LIN_NOID,
        UCSE_MODE_CARD
    } ucse_mode_t;
    typedef enum logic [1:0] {
        UCSE_ERR_IDLE,
        UCSE_ERR_HOLD
    } ucse_err_t;
endpackage

// ### hw/ucse_sum8.sv
// Purpose: One end-around-carry byte adder.
// Assumes: Purely combinational.
// Notes: Folds the carry back into the low bit.
`timescale 1ns/1ps
`default_nettype none
module ucse_sum8 (
    input  wire logic [7:0] acc,
    input  wire logic [7:0] data,
    output logic      [7:0] sum
);
    logic [8:0] raw;
    always_comb begin
        raw = {1'b0, acc} + {1'b0, data};
        sum = raw[7:0] + {7'h00, raw[8]};
    end
endmodule
`default_nettype wire

// ### verif/ucse_sva.sv
// Purpose: Port checks for the checksum, smart-card and event interrupt block.
// Assumes: Only the top module ports are visible.
// Notes: The rate-detect enable is mirrored from control register writes.
`timescale 1ns/1ps
`default_nettype none
module ucse_sva (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        rx_byte_valid,
    input wire logic        tx_char_error,
    input wire logic        waiting_expired,
    input wire logic        rate_detect_final_edge,
    input wire logic [1:0]  retry_count_select,
    input wire logic        bit_sense_inverse,
    input wire logic        card_protocol_t1,
    input wire logic        card_irq,
    input wire logic        event_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic        rate_en_q;
    logic [15:0] wd_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rate_en_q <= 1'h0;
            wd_q      <= 16'h0000;
        end else begin
            wd_q <= reg_wdata;
            if (reg_wr && reg_addr == 4'h5) rate_en_q <= reg_wdata[4];
        end
    end
    sequence s_rate_then_read;
        rate_detect_final_edge && rate_en_q ##[1:2] reg_rd && reg_addr == 4'h4;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data seen outside a read slot");
    a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 16'h0000)
        else $error("unmapped index read nonzero");
    a_sum_upper: assert property (reg_rd && reg_addr <= 4'h1 |=> reg_rdata[15:8] == 8'h00)
        else $error("checksum upper byte nonzero");
    a_cfg_rsvd: assert property (reg_rd && reg_addr == 4'h2 |=> (reg_rdata & 16'hFFC1) == 0)
        else $error("card config reserved bits nonzero");
    a_cirq_rsvd: assert property (reg_rd && reg_addr == 4'h3 |=> (reg_rdata & 16'hC8C8) == 0)
        else $error("card irq reserved bits nonzero");
    a_evirq_rsvd: assert property (reg_rd && reg_addr == 4'h4 |=> (reg_rdata & 16'hFF3B) == 0)
        else $error("event reserved bits nonzero");
    a_cfg_levels: assert property (reg_wr && reg_addr == 4'h2 |=>
        {retry_count_select, bit_sense_inverse, card_protocol_t1} == {wd_q[5:3], wd_q[1]})
        else $error("card config outputs differ from write");
    a_rate_flag: assert property (s_rate_then_read |=> reg_rdata[6])
        else $error("rate done flag not set");
    a_event_irq: assert property (reg_rd && reg_addr == 4'h4 && !rate_detect_final_edge |=>
        event_irq == (reg_rdata[7] | (reg_rdata[6] & reg_rdata[2])))
        else $error("event irq differs from flags");
    a_card_irq: assert property (reg_rd && reg_addr == 4'h3 && !rx_byte_valid &&
        !tx_char_error && !waiting_expired |=> card_irq == |(reg_rdata[13:8] & reg_rdata[5:0]))
        else $error("card irq differs from flags");
endmodule
bind ucse_top ucse_sva i_sva (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_byte_valid(rx_byte_valid),
    .tx_char_error(tx_char_error), .waiting_expired(waiting_expired),
    .rate_detect_final_edge(rate_detect_final_edge), .retry_count_select(retry_count_select),
    .bit_sense_inverse(bit_sense_inverse), .card_protocol_t1(card_protocol_t1),
    .card_irq(card_irq), .event_irq(event_irq)
);
`default_nettype wire

// ### verif/ucse_line_model.sv
// Purpose: Far-side line node or card feeding received characters and line edges.
// Assumes: Driven on core_clk rising edges.
// Notes: The pin idles high; a released byte bus shows the inverse value.
`timescale 1ns/1ps
`default_nettype none
module ucse_line_model (
    input  wire logic core_clk,
    output logic      rx_pin,
    output logic      rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic      rx_char_error,
    output logic      break_seen
);
    initial begin
        rx_pin = 1'h1;
        rx_byte_valid = 1'h0;
        rx_byte = 8'h00;
        rx_char_error = 1'h0;
        break_seen = 1'h0;
    end
    task automatic send(input logic [7:0] b, input logic err);
        @(posedge core_clk);
        rx_byte_valid <= 1'h1;
        rx_byte <= b;
        rx_char_error <= err;
        @(posedge core_clk);
        rx_byte_valid <= 1'h0;
        rx_byte <= ~b;
        rx_char_error <= 1'h0;
    endtask
    task automatic fall();
        @(posedge core_clk);
        rx_pin <= 1'h0;
        repeat (3) @(posedge core_clk);
        rx_pin <= 1'h1;
    endtask
    task automatic brk();
        @(posedge core_clk);
        break_seen <= 1'h1;
        @(posedge core_clk);
        break_seen <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ### verif/ucse_top_tb.sv
// Purpose: Register-level bench for the checksum, smart-card and event block.
// Assumes: Bit-clock divider set to 2, three cycles per unit.
// Notes: Received traffic comes from the line model; core strobes from here.
`timescale 1ns/1ps
`default_nettype none
module ucse_top_tb
    import ucse_pkg::*;
;
    logic        core_clk = 1'h0;
    logic        reset_n = 1'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'h0, reg_rd = 1'h0, tx_v = 1'h0, tx_pid = 1'h0, tx_err = 1'h0;
    logic        wait_x = 1'h0, rate_e = 1'h0;
    logic [7:0]  tx_b = 8'h00;
    ucse_mode_t  line_mode = UCSE_MODE_PLAIN;
    logic [15:0] reg_rdata;
    logic        rx_pin, rx_v, rx_err, brk, sense, proto, hold, cirq, eirq;
    logic [7:0]  rx_b;
    logic [1:0]  retry;
    logic [15:0] msk [5] = '{16'h00FF, 16'h00FF, 16'h003E, 16'h0037, 16'h0004};
    int          error_cnt = 0, n_compared = 0, n;
    always #5 core_clk = ~core_clk;
    ucse_top i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_mode(line_mode),
        .tx_byte_valid(tx_v), .tx_byte(tx_b), .tx_byte_is_pid(tx_pid), .rx_byte_valid(rx_v),
        .rx_byte(rx_b), .break_seen(brk), .rx_pin(rx_pin), .rx_char_error(rx_err),
        .tx_char_error(tx_err), .waiting_expired(wait_x), .rate_detect_final_edge(rate_e),
        .bit_sense_inverse(sense), .card_protocol_t1(proto), .retry_count_select(retry),
        .error_hold_low(hold), .card_irq(cirq), .event_irq(eirq)
    );
    ucse_line_model i_peer (
        .core_clk(core_clk), .rx_pin(rx_pin), .rx_byte_valid(rx_v), .rx_byte(rx_b),
        .rx_char_error(rx_err), .break_seen(brk)
    );
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic tx(input logic [7:0] b, input logic p);
        @(posedge core_clk);
        tx_v <= 1'h1;
        tx_b <= b;
        tx_pid <= p;
        @(posedge core_clk);
        tx_v <= 1'h0;
    endtask
    task automatic hold_len(input int u);
        int c;
        c = 0;
        n = 0;
        #1;
        while (hold !== 1'h1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        while (hold === 1'h1 && c < 40) begin
            @(posedge core_clk);
            c++;
        end
        chk({15'h0, n < 40 && c == 3 * u + 1}, 16'h0001);
        if (n >= 40) end_sim();
    endtask
    initial begin
        #500000;
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'h1;
        for (int a = 0; a < 16; a++) rc(a[3:0], (a == 8) ? 16'h0174 : 16'h0000);
        for (int a = 0; a < 5; a++) begin
            wr(a[3:0], 16'hFFFF);
            rc(a[3:0], msk[a]);
            wr(a[3:0], 16'h0000);
        end
        wr(4'h5, 16'h0004);
        tx(8'hF0, 1'h1);
        tx(8'h20, 1'h0);
        i_peer.send(8'hFF, 1'h0);
        i_peer.send(8'h02, 1'h0);
        rc(4'h0, 16'h0011);
        rc(4'h1, 16'h0002);
        wr(4'h5, 16'h0000);
        tx(8'h33, 1'h0);
        i_peer.send(8'h44, 1'h0);
        rc(4'h0, 16'h0011);
        rc(4'h1, 16'h0002);
        @(posedge core_clk);
        line_mode <= UCSE_MODE_LIN;
        i_peer.brk();
        rc(4'h0, 16'h0000);
        rc(4'h1, 16'h0000);
        @(posedge core_clk);
        line_mode <= UCSE_MODE_LIN_NOID;
        tx(8'h55, 1'h1);
        tx(8'hC0, 1'h0);
        tx(8'h50, 1'h0);
        rc(4'h0, 16'h0011);
        for (int i = 0; i < 32; i++) begin
            wr(4'h2, 16'(i) << 1);
            rc(4'h2, 16'(i) << 1);
            chk({12'h0, retry, sense, proto}, {12'h0, i[4:2], i[0]});
        end
        @(posedge core_clk);
        line_mode <= UCSE_MODE_CARD;
        wr(4'h8, 16'h0002);
        wr(4'h2, 16'h0004);
        wr(4'h3, 16'h0020);
        for (int k = 1; k <= 5; k++) begin
            if (k == 5) wr(4'h2, 16'h0000);
            i_peer.send(8'hA5, 1'h1);
            hold_len((k == 5) ? 1 : 2);
            rc(4'h3, (k == 5) ? 16'h2020 : 16'h0020);
        end
        chk({15'h0, cirq}, 16'h0001);
        wr(4'h3, 16'h0000);
        rc(4'h3, 16'h2000);
        chk({15'h0, cirq}, 16'h0000);
        wr(4'h3, 16'h2000);
        rc(4'h3, 16'h0000);
        wr(4'h6, 16'h0004);
        wr(4'h7, 16'h0006);
        rc(4'h3, 16'h0000);
        @(posedge core_clk);
        wait_x <= 1'h1;
        @(posedge core_clk);
        wait_x <= 1'h0;
        repeat (24) @(posedge core_clk);
        rc(4'h3, 16'h0700);
        chk({15'h0, cirq}, 16'h0000);
        wr(4'h3, 16'h0004);
        rc(4'h3, 16'h0704);
        chk({15'h0, cirq}, 16'h0001);
        wr(4'h2, 16'h0020);
        for (int j = 0; j < 3; j++) begin
            @(posedge core_clk);
            tx_err <= 1'h1;
            @(posedge core_clk);
            tx_err <= 1'h0;
            rc(4'h3, (j == 2) ? 16'h1704 : 16'h0704);
        end
        chk({15'h0, cirq}, 16'h0001);
        wr(4'h5, 16'h0008);
        i_peer.fall();
        repeat (4) @(posedge core_clk);
        rc(4'h4, 16'h0080);
        chk({15'h0, eirq}, 16'h0001);
        wr(4'h4, 16'h0000);
        rc(4'h4, 16'h0080);
        wr(4'h4, 16'h0080);
        rc(4'h4, 16'h0000);
        wr(4'h5, 16'h0010);
        i_peer.fall();
        @(posedge core_clk);
        rate_e <= 1'h1;
        @(posedge core_clk);
        rate_e <= 1'h0;
        rc(4'h4, 16'h0040);
        chk({15'h0, eirq}, 16'h0000);
        wr(4'h4, 16'h0004);
        rc(4'h4, 16'h0044);
        chk({15'h0, eirq}, 16'h0001);
        wr(4'h4, 16'h0044);
        rc(4'h4, 16'h0004);
        chk({15'h0, eirq}, 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
